/* File: cgsm_config_slave.sv */
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module cgsm_config_slave (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n,
  input wire cgsm_pkg::cgsm_strap_t strapPins,
  input wire logic powerGoodStrobe,
  input wire logic suspendPowered,
  input wire logic testMode,
  input wire logic [5:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  output logic [31:0] avsReadData,
  output logic avsWaitrequest,
  output cgsm_pkg::cgsm_strap_t strapsLatched,
  output logic strapsValid,
  output cgsm_pkg::cgsm_freq_t freqSelected,
  output logic refClk25En,
  output logic powerDown,
  output logic stopOutputs
);
  import cgsm_pkg::*;

  cgsm_state_t st_r;
  cgsm_state_t st_nxt;
  logic sclNew;
  logic sdaNew;
  logic pgNew;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic wle;
  logic smbWrite;
  logic avReq;
  logic [7:0] rxByte;
  logic [7:0] txByte;

  function automatic logic [7:0] readByte(input logic [6:0] idx, input cgsm_state_t s);
    logic [7:0] b;
    b = 8'h00;
    if (idx == VID_INDEX) begin
      b = VENDOR_ID;
    end else if (idx == 7'h00) begin
      b = {3'h0, s.straps.storageRefSel, 1'b0, s.straps.freqSel} | (s.ctl[0] & BYTE0_WMASK);
    end else if (idx < VID_INDEX) begin
      b = s.ctl[idx[2:0]];
    end
    return b;
  endfunction : readByte

  function automatic logic [6:0][7:0] writeCtl(input logic [6:0][7:0] c,
                                               input logic [6:0] idx, input logic [7:0] d);
    logic [6:0][7:0] r;
    r = c;
    if (idx == 7'h00) begin
      r[0] = d & BYTE0_WMASK;
    end else if (idx < VID_INDEX) begin
      r[idx[2:0]] = d;
    end
    return r;
  endfunction : writeCtl

  always_comb begin
    st_nxt = st_r;
    st_nxt.sclS = {st_r.sclS[1:0], sclIn};
    st_nxt.sdaS = {st_r.sdaS[1:0], sdaIn};
    st_nxt.pgS = {st_r.pgS[1:0], powerGoodStrobe};
    st_nxt.strapS = {st_r.strapS[1:0], strapPins};
    sclNew = (st_r.sclS[1] == st_r.sclS[2]) ? st_r.sclS[2] : st_r.sclF;
    sdaNew = (st_r.sdaS[1] == st_r.sdaS[2]) ? st_r.sdaS[2] : st_r.sdaF;
    pgNew = (st_r.pgS[1] == st_r.pgS[2]) ? st_r.pgS[2] : st_r.pgF;
    st_nxt.sclF = sclNew;
    st_nxt.sdaF = sdaNew;
    st_nxt.pgF = pgNew;
    sclRise = sclNew & ~st_r.sclF;
    sclFall = ~sclNew & st_r.sclF;
    startCond = st_r.sclF & sclNew & st_r.sdaF & ~sdaNew;
    stopCond = st_r.sclF & sclNew & ~st_r.sdaF & sdaNew;
    rxByte = st_r.shift;
    txByte = 8'h00;
    wle = st_r.ctl[WLE_BYTE][WLE_BIT];
    smbWrite = sclFall && st_r.fsm == S_RECV && st_r.bitCnt == BIT_LAST_RX
               && st_r.phase == P_DATA;
    avReq = avsRead | avsWrite;

    if (pgNew && (!st_r.latched || testMode) && st_r.strapS[1] == st_r.strapS[2]) begin
      st_nxt.latched = 1'b1;
      st_nxt.straps = st_r.strapS[2];
      st_nxt.freq = decodeFreq(st_r.strapS[2]);
    end

    st_nxt.powerDown = ~wle & ~pgNew;
    st_nxt.refEn = suspendPowered & ~st_nxt.powerDown;
    st_nxt.stopOutputs = wle & st_r.latched & ~pgNew;

    if (sclRise && st_r.fsm == S_RECV) begin
      st_nxt.shift = {st_r.shift[6:0], sdaNew};
      st_nxt.bitCnt = st_r.bitCnt + 4'h1;
    end
    if (sclRise && st_r.fsm == S_MACK) begin
      st_nxt.masterAck = ~sdaNew;
    end

    if (sclFall) begin
      case (st_r.fsm)
        S_RECV: begin
          if (st_r.bitCnt == BIT_LAST_RX) begin
            st_nxt.fsm = S_ACK;
            st_nxt.sdaDrive = 1'b1;
            st_nxt.bitCnt = 4'h0;
            case (st_r.phase)
              P_ADDR: begin
                if (rxByte[7:1] != SLAVE_ADDR_BYTE[7:1]) begin
                  st_nxt.fsm = S_IDLE;
                  st_nxt.sdaDrive = 1'b0;
                end
                st_nxt.readDir = rxByte[0];
              end
              P_CMD: begin
                st_nxt.blockMode = ~rxByte[CMD_SINGLE_BIT];
                st_nxt.index = rxByte[CMD_SINGLE_BIT] ? rxByte[6:0] : 7'h00;
              end
              P_CNT: begin
                st_nxt.phase = P_CNT;
              end
              default: begin
                st_nxt.ctl = writeCtl(st_r.ctl, st_r.index, rxByte);
                st_nxt.index = st_r.index + 7'h1;
              end
            endcase
          end
        end
        S_ACK: begin
          st_nxt.sdaDrive = 1'b0;
          if (st_r.readDir) begin
            txByte = st_r.blockMode ? BLOCK_COUNT : readByte(st_r.index, st_r);
            st_nxt.phase = st_r.blockMode ? P_CNT : P_DATA;
            st_nxt.fsm = S_SEND;
            st_nxt.shift = txByte;
            st_nxt.sdaDrive = ~txByte[7];
          end else begin
            st_nxt.fsm = S_RECV;
            case (st_r.phase)
              P_ADDR: st_nxt.phase = P_CMD;
              P_CMD: st_nxt.phase = st_r.blockMode ? P_CNT : P_DATA;
              default: st_nxt.phase = P_DATA;
            endcase
          end
        end
        S_SEND: begin
          if (st_r.bitCnt == BIT_LAST_TX) begin
            st_nxt.fsm = S_MACK;
            st_nxt.sdaDrive = 1'b0;
            st_nxt.phase = P_DATA;
            if (st_r.phase == P_DATA) begin
              st_nxt.index = st_r.index + 7'h1;
            end
          end else begin
            st_nxt.bitCnt = st_r.bitCnt + 4'h1;
            st_nxt.shift = {st_r.shift[6:0], 1'b0};
            st_nxt.sdaDrive = ~st_r.shift[6];
          end
        end
        S_MACK: begin
          if (st_r.masterAck) begin
            txByte = readByte(st_r.index, st_r);
            st_nxt.fsm = S_SEND;
            st_nxt.bitCnt = 4'h0;
            st_nxt.shift = txByte;
            st_nxt.sdaDrive = ~txByte[7];
          end else begin
            st_nxt.fsm = S_IDLE;
          end
        end
        default: begin
          st_nxt.fsm = S_IDLE;
        end
      endcase
    end

    if (startCond) begin
      st_nxt.fsm = S_RECV;
      st_nxt.phase = P_ADDR;
      st_nxt.bitCnt = 4'h0;
      st_nxt.sdaDrive = 1'b0;
    end
    if (stopCond) begin
      st_nxt.fsm = S_IDLE;
      st_nxt.sdaDrive = 1'b0;
    end

    // Bus access yields to a serial write in the same cycle
    st_nxt.avAck = 1'b0;
    if (avReq && !st_r.avAck && !smbWrite) begin
      st_nxt.avAck = 1'b1;
      st_nxt.avData = 8'h00;
      if (avsAddress < AV_MAP_LIMIT) begin
        st_nxt.avData = readByte({4'h0, avsAddress[4:2]}, st_r);
        if (avsWrite) begin
          st_nxt.ctl = writeCtl(st_nxt.ctl, {4'h0, avsAddress[4:2]}, avsWriteData[7:0]);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= stReset();
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOe_n = ~st_r.sdaDrive;
  assign avsWaitrequest = avReq & ~st_r.avAck;
  assign avsReadData = {24'h000000, st_r.avData};
  assign strapsLatched = st_r.straps;
  assign strapsValid = st_r.latched;
  assign freqSelected = st_r.freq;
  assign refClk25En = st_r.refEn;
  assign powerDown = st_r.powerDown;
  assign stopOutputs = st_r.stopOutputs;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence byteDone;
    sclFall && st_r.fsm == S_RECV && st_r.bitCnt == BIT_LAST_RX && !stopCond;
  endsequence
  sequence addrDone;
    byteDone and (st_r.phase == P_ADDR);
  endsequence
  sequence cmdDone;
    byteDone and (st_r.phase == P_CMD);
  endsequence
  sequence hostNack;
    sclFall && st_r.fsm == S_MACK && !st_r.masterAck && !startCond;
  endsequence

  foreign_addr_a: assert property (
    addrDone and (rxByte[7:1] != SLAVE_ADDR_BYTE[7:1])
    |=> st_r.fsm == S_IDLE && !st_r.sdaDrive)
    else $error("foreign address not released");
  own_addr_a: assert property (
    addrDone and (rxByte[7:1] == SLAVE_ADDR_BYTE[7:1])
    |=> st_r.fsm == S_ACK && !sdaOe_n)
    else $error("own address not acknowledged");
  single_index_a: assert property (
    cmdDone and rxByte[7] |=> !st_r.blockMode && st_r.index == $past(rxByte[6:0]))
    else $error("single index not taken");
  block_cmd_a: assert property (
    cmdDone and !rxByte[7] |=> st_r.blockMode && st_r.index == 7'h00)
    else $error("block command misdecoded");
  index_step_a: assert property (
    byteDone and (st_r.phase == P_DATA) |=> st_r.index == $past(st_r.index) + 7'h1)
    else $error("register index did not step");
  nack_end_a: assert property (
    hostNack |=> st_r.fsm == S_IDLE && sdaOe_n)
    else $error("read continued after nack");
  strap_hold_a: assert property (
    st_r.latched && !testMode |=> $stable(st_r.straps) && st_r.latched)
    else $error("straps changed after capture");
  strap_pg_a: assert property (
    $rose(st_r.latched) |-> st_r.pgF)
    else $error("straps captured without power-good");
  cpu_top_a: assert property (
    st_r.latched && st_r.straps.freqSel[2:1] == 2'b11 |-> st_r.freq.cpu == MHZ166_67)
    else $error("cpu frequency misdecoded");
  ref_on_a: assert property (
    suspendPowered && wle |=> refClk25En && !powerDown)
    else $error("reference dropped with wake enable set");
  pd_pin_a: assert property (
    !wle ##1 !st_r.pgF |-> powerDown && !refClk25En)
    else $error("power-down pin ignored");
  bus_wait_a: assert property (
    avReq |-> ##[0:2] !avsWaitrequest)
    else $error("bus request not answered");
endmodule : cgsm_config_slave

/* File: cgsm_host_model.sv */
`timescale 1ns/1ps
module cgsm_host_model (
  output logic scl,
  output logic sdaHost,
  input wire logic sdaWire,
  output logic resStrobe,
  output logic [7:0] resByte
);
  localparam time Q = 40ns;
  initial begin
    scl = 1'b1;
    sdaHost = 1'b1;
    resStrobe = 1'b0;
    resByte = 8'h00;
  end
  task automatic start();
    #Q sdaHost = 1'b1;
    #Q scl = 1'b1;
    #Q sdaHost = 1'b0;
    #Q scl = 1'b0;
  endtask : start
  task automatic stop();
    #Q sdaHost = 1'b0;
    #Q scl = 1'b1;
    #Q sdaHost = 1'b1;
    #Q;
  endtask : stop
  task automatic bitT(input logic o, output logic s);
    #Q sdaHost = o;
    #Q scl = 1'b1;
    #Q s = sdaWire;
    #Q scl = 1'b0;
  endtask : bitT
  // MSB first, host ack or nack
  task automatic byteX(input logic rd, input logic [7:0] d);
    logic [7:0] v;
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bitT(rd ? 1'b1 : d[i], v[i]);
    end
    bitT(rd ? d[0] : 1'b1, a);
    resByte = rd ? v : {7'h00, a};
    resStrobe = 1'b1;
    #1 resStrobe = 1'b0;
  endtask : byteX
endmodule : cgsm_host_model

/* File: cgsm_pkg.sv */
package cgsm_pkg;
  localparam logic [7:0] SLAVE_ADDR_BYTE = 8'hd2;
  localparam logic [7:0] BLOCK_COUNT = 8'h08;
  // Arbitrary value
  localparam logic [7:0] VENDOR_ID = 8'h5a;
  localparam logic [6:0] VID_INDEX = 7'h07;
  localparam int WLE_BYTE = 1;
  localparam int WLE_BIT = 1;
  localparam int CMD_SINGLE_BIT = 7;
  localparam logic [7:0] BYTE0_WMASK = 8'h20;
  localparam logic [6:0][7:0] CTL_RESET = {8'h55, 8'h10, 8'h00, 8'hc0, 8'hbe, 8'hfe, 8'h00};
  localparam logic [3:0] BIT_LAST_RX = 4'h8;
  localparam logic [3:0] BIT_LAST_TX = 4'h7;
  localparam logic [5:0] AV_MAP_LIMIT = 6'h20;
  // Frequencies in units of 10 kHz
  localparam logic [15:0] MHZ100_00 = 16'h2710;
  localparam logic [15:0] MHZ83_33 = 16'h208d;
  localparam logic [15:0] MHZ133_33 = 16'h3415;
  localparam logic [15:0] MHZ166_67 = 16'h411b;
  localparam logic [15:0] MHZ75_00 = 16'h1d4c;
  localparam logic [15:0] MHZ33_33 = 16'h0d05;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_RECV = 5'h02,
    S_ACK = 5'h04,
    S_SEND = 5'h08,
    S_MACK = 5'h10
  } cgsm_fsm_t;

  typedef enum logic [3:0] {
    P_ADDR = 4'h1,
    P_CMD = 4'h2,
    P_CNT = 4'h4,
    P_DATA = 4'h8
  } cgsm_phase_t;

  typedef struct packed {
    logic storageRefSel;
    logic [2:0] freqSel;
  } cgsm_strap_t;

  typedef struct packed {
    logic [15:0] cpu;
    logic [15:0] serialRef;
    logic [15:0] storageRef;
    logic [15:0] pci;
  } cgsm_freq_t;

  typedef struct packed {
    logic [2:0] sclS;
    logic [2:0] sdaS;
    logic [2:0] pgS;
    logic [2:0][3:0] strapS;
    logic sclF;
    logic sdaF;
    logic pgF;
    logic latched;
    cgsm_strap_t straps;
    cgsm_freq_t freq;
    cgsm_fsm_t fsm;
    cgsm_phase_t phase;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic readDir;
    logic blockMode;
    logic masterAck;
    logic [6:0] index;
    logic sdaDrive;
    logic [6:0][7:0] ctl;
    logic avAck;
    logic [7:0] avData;
    logic refEn;
    logic powerDown;
    logic stopOutputs;
  } cgsm_state_t;

  function automatic cgsm_freq_t decodeFreq(input cgsm_strap_t sp);
    cgsm_freq_t f;
    f.serialRef = MHZ100_00;
    f.pci = MHZ33_33;
    f.storageRef = sp.storageRefSel ? MHZ75_00 : MHZ100_00;
    case (sp.freqSel[2:1])
      2'b00: f.cpu = MHZ100_00;
      2'b01: f.cpu = MHZ83_33;
      2'b10: f.cpu = MHZ133_33;
      default: f.cpu = MHZ166_67;
    endcase
    return f;
  endfunction : decodeFreq

  function automatic cgsm_state_t stReset();
    cgsm_state_t s;
    s = '0;
    s.sclS = 3'h7;
    s.sdaS = 3'h7;
    s.sclF = 1'b1;
    s.sdaF = 1'b1;
    s.freq = decodeFreq('0);
    s.fsm = S_IDLE;
    s.phase = P_ADDR;
    s.ctl = CTL_RESET;
    s.refEn = 1'b1;
    return s;
  endfunction : stReset
endpackage : cgsm_pkg

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
  import cgsm_pkg::*;
  logic clk, reset_n, scl, sdaHost, sdaOut, sdaOe_n, resStrobe, powerGoodStrobe;
  logic suspendPowered, testMode, avsRead, avsWrite, avsWaitrequest;
  logic strapsValid, refClk25En, powerDown, stopOutputs;
  logic [5:0] avsAddress;
  logic [31:0] avsWriteData, avsReadData, expQ[$];
  logic [7:0] resByte, d, mdl[8];
  cgsm_strap_t strapPins, strapsLatched, capS, lat;
  cgsm_freq_t freqSelected;
  int fails, samplesChecked, seedDump;
  wire sdaW = sdaHost & (sdaOe_n | sdaOut);
  cgsm_config_slave i_cgsm_config_slave (.clk(clk), .reset_n(reset_n), .sclIn(scl),
    .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .strapPins(strapPins),
    .powerGoodStrobe(powerGoodStrobe), .suspendPowered(suspendPowered), .testMode(testMode),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsReadData(avsReadData), .avsWaitrequest(avsWaitrequest),
    .strapsLatched(strapsLatched), .strapsValid(strapsValid), .freqSelected(freqSelected),
    .refClk25En(refClk25En), .powerDown(powerDown), .stopOutputs(stopOutputs));
  cgsm_host_model i_cgsm_host_model (.scl(scl), .sdaHost(sdaHost), .sdaWire(sdaW),
    .resStrobe(resStrobe), .resByte(resByte));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    #400us;
    fails++;
    $display("Error at %0t: run hung", $time);
    end_of_test();
  end
  task automatic check(input logic [63:0] s, input logic [63:0] e);
    samplesChecked++;
    if (s !== e) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic take(input logic [31:0] s);
    check({32'h0, s}, expQ.size() > 0 ? {32'h0, expQ.pop_front()} : 'x); // queued result
  endtask : take
  always @(posedge clk) if (avsRead === 1'b1 && avsWaitrequest === 1'b0) take(avsReadData);
  always @(posedge resStrobe) take({24'h0, resByte});
  task automatic av(input logic w, input logic [5:0] a, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk);
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWriteData <= ($urandom() & 32'hffffff00) | {24'h0, v};
    @(posedge clk);
    while (avsWaitrequest !== 1'b0 && n < 50) begin
      n++;
      @(posedge clk);
    end
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    if (n == 50) begin
      fails++;
      end_of_test();
    end
  endtask : av
  task automatic upd(input int i, input logic [7:0] v);
    if (i == 0) mdl[0] = v & BYTE0_WMASK;
    else if (i < 7) mdl[i] = v;
  endtask : upd
  function automatic logic [7:0] rdExp(input int i);
    return i == 0 ? mdl[0] | {3'b000, lat.storageRefSel, 1'b0, lat.freqSel} : mdl[i];
  endfunction : rdExp
  function automatic cgsm_freq_t fExp(input cgsm_strap_t s);
    logic [15:0] cpu[4];
    cpu = '{MHZ100_00, MHZ83_33, MHZ133_33, MHZ166_67};
    return {cpu[s.freqSel[2:1]], MHZ100_00, s.storageRefSel ? MHZ75_00 : MHZ100_00, MHZ33_33};
  endfunction : fExp
  task automatic avRd(input logic [5:0] a, input logic [7:0] e);
    expQ.push_back({24'h0, e});
    av(1'b0, a, 8'h00);
  endtask : avRd
  task automatic wr(input int i, input logic [7:0] v);
    av(1'b1, 6'(4 * i), v);
    upd(i, v);
  endtask : wr
  task automatic sb(input logic rd, input logic [7:0] v, input logic [7:0] e);
    expQ.push_back({24'h0, e});
    i_cgsm_host_model.byteX(rd, v);
  endtask : sb
  task automatic st();
    @(negedge clk);
    i_cgsm_host_model.start();
  endtask : st
  task automatic sp();
    i_cgsm_host_model.stop();
    @(posedge clk);
  endtask : sp
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask : settle
  task automatic note(input string s);
    $display("test %s done", s);
  endtask : note
  initial begin
    reset_n = 1'b0;
    powerGoodStrobe = 1'b0;
    suspendPowered = 1'b1;
    testMode = 1'b0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsAddress = 6'h00;
    avsWriteData = 32'h0;
    strapPins = '0;
    lat = '0;
    fails = 0;
    samplesChecked = 0;
    seedDump = $urandom(32'h0a4e8ca1);
    for (int i = 0; i < 7; i++) mdl[i] = CTL_RESET[i];
    mdl[7] = VENDOR_ID;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    check({refClk25En, strapsValid}, 2'b10); // ref on at power-up
    for (int i = 0; i < 8; i++) avRd(6'(4 * i), rdExp(i)); // defaults
    wr(7, 8'h00);
    wr(9, 8'($urandom()));
    avRd(6'h1c, VENDOR_ID); // read-only byte
    avRd(6'h24, 8'h00); // unmapped
    note("registers");
    capS = cgsm_strap_t'(4'($urandom()));
    strapPins <= capS;
    settle();
    check(strapsValid, 1'b0); // no capture yet
    powerGoodStrobe <= 1'b1; // straps set first
    settle();
    lat = capS;
    check({strapsValid, strapsLatched}, {1'b1, capS}); // captured
    check(freqSelected, fExp(capS)); // decode
    strapPins <= ~capS;
    powerGoodStrobe <= 1'b0;
    settle();
    powerGoodStrobe <= 1'b1;
    settle();
    check({strapsLatched, freqSelected}, {capS, fExp(capS)}); // one-shot
    avRd(6'h00, rdExp(0)); // straps in byte 0
    testMode <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      strapPins <= 4'(i);
      settle();
      check(freqSelected, fExp(4'(i))); // every code
    end
    strapPins <= capS;
    settle();
    testMode <= 1'b0;
    note("straps");
    powerGoodStrobe <= 1'b0;
    settle();
    check({refClk25En, powerDown, stopOutputs}, 3'b101); // ref stays on
    wr(1, 8'($urandom()) & 8'hfd);
    settle();
    check({refClk25En, powerDown, stopOutputs}, 3'b010); // pin is power-down
    powerGoodStrobe <= 1'b1;
    settle();
    check(powerDown, 1'b0); // released
    suspendPowered <= 1'b0;
    settle();
    check(refClk25En, 1'b0); // no suspend supply
    suspendPowered <= 1'b1;
    settle();
    check(refClk25En, 1'b1); // supply back
    st();
    sb(1'b0, SLAVE_ADDR_BYTE, 8'h00); // own address
    sb(1'b0, 8'h81, 8'h00); // single index 1
    sb(1'b0, 8'hfe, 8'h00); // data acked
    sp();
    upd(1, 8'hfe);
    powerGoodStrobe <= 1'b0;
    settle();
    check({powerDown, stopOutputs}, 2'b01); // write took effect
    powerGoodStrobe <= 1'b1;
    note("wake");
    st();
    sb(1'b0, SLAVE_ADDR_BYTE, 8'h00);
    sb(1'b0, 8'h81, 8'h00);
    st();
    sb(1'b0, SLAVE_ADDR_BYTE | 8'h01, 8'h00); // read address
    sb(1'b1, 8'h01, mdl[1]); // one byte, nack
    sp();
    st();
    sb(1'b0, 8'ha0, 8'h01); // no ack
    sp();
    st();
    sb(1'b0, SLAVE_ADDR_BYTE, 8'h00);
    sb(1'b0, 8'h00, 8'h00); // block
    sb(1'b0, 8'h03, 8'h00); // count acked
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom());
      sb(1'b0, d, 8'h00); // data acked
      upd(i, d);
    end
    sp();
    st();
    sb(1'b0, SLAVE_ADDR_BYTE, 8'h00);
    sb(1'b0, 8'h00, 8'h00);
    st();
    sb(1'b0, SLAVE_ADDR_BYTE | 8'h01, 8'h00);
    sb(1'b1, 8'h00, BLOCK_COUNT); // count first
    for (int i = 0; i < 3; i++) sb(1'b1, {7'h00, i == 2}, rdExp(i)); // ascending
    sp();
    avRd(6'h08, mdl[2]); // block data stored
    settle();
    check(expQ.size(), 0); // all results seen
    note("serial");
    end_of_test();
  end
endmodule : tb
